// file: verilog/loopback_pkg.sv
// Package: constants for the regenerator loopback control block
package loopback_pkg;

	// ----------------------------------------------------------------
	// Message fields
	// ----------------------------------------------------------------
	localparam int          ADDR_W        = 2;
	localparam int          CODE_W        = 8;
	localparam logic [1:0]  REG_ADDR      = 2'h2;
	localparam logic [7:0]  CODE_LOOP_REQ = 8'h01;
	localparam logic [7:0]  CODE_RETURN   = 8'h02;
	localparam logic [7:0]  CODE_HOLD     = 8'h03;

	// ----------------------------------------------------------------
	// Indicator bits
	// ----------------------------------------------------------------
	localparam int          IND_W         = 8;
	localparam logic [7:0]  REG_IND_MASK  = 8'h07;
	localparam int          READY_BIT     = 3;
	localparam int          READY_FRAMES  = 6;

	// ----------------------------------------------------------------
	// Customer-side transceiver reset pulse
	// ----------------------------------------------------------------
	localparam int          RESET_NS      = 100;
	localparam int          CLK_NS        = 10;
	localparam int          RESET_CYC     = (RESET_NS + CLK_NS - 1) / CLK_NS;

	// ----------------------------------------------------------------
	// Control states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_NORMAL   = 4'h1,
		ST_LOOP_RST = 4'h2,
		ST_LOOPED   = 4'h4,
		ST_RESTART  = 4'h8
	} loop_state_t;

endpackage : loopback_pkg

// file: verilog/ready_filter.sv
// Consecutive-frame qualifier for the remote-ready indicator
`timescale 1ns/100ps
module ready_filter #(
	parameter int FRAMES = loopback_pkg::READY_FRAMES
) (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic rst_n_i,
	// Frame indicator sample
	input  wire logic frame_i,
	input  wire logic bit_i,
	input  wire logic clear_i,
	// Qualified level
	output logic      ready_o
);
	logic [3:0] count_q;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_q <= 4'h0;
		end else if (clear_i) begin
			count_q <= 4'h0;
		end else if (frame_i) begin
			if (!bit_i)
				count_q <= 4'h0;
			else if (count_q < 4'(FRAMES))
				count_q <= count_q + 4'h1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			ready_o <= 1'b0;
		else
			ready_o <= !clear_i && (count_q >= 4'(FRAMES) ||
				(frame_i && bit_i && count_q == 4'(FRAMES - 1)));
	end

	chk_ready_needs_run: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		$rose(ready_o) |-> $past(count_q) == 4'(FRAMES - 1))
		else $error("ready rose without full run of frames");

endmodule : ready_filter

// file: verilog/regen_loopback_ctrl.sv
// Regenerator transparent loopback control toward the exchange side
// Operation
// - Close loop on request when link active
// - Looped signal also passes to customer side
// - Own-address messages keep working while looped
// - Foreign address answered with hold, own address
// - Loop indicators except three regenerator bits
// - Return message after reset phase: deactivate customer transceiver, unloop
// - After release, restart customer link if active
// - Reset customer transceiver on loop entry
// - Ready set only after six consecutive frames
`timescale 1ns/100ps
module regen_loopback_ctrl #(
	parameter int RESET_CYCLES = loopback_pkg::RESET_CYC
) (
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	// Exchange-side link status
	input  wire logic       xchg_active_i,
	// Operations channel message from the exchange side
	input  wire logic       msg_valid_i,
	input  wire logic [1:0] msg_addr_i,
	input  wire logic [7:0] msg_code_i,
	// Operations channel message toward the exchange side
	input  wire logic       own_msg_valid_i,
	input  wire logic [7:0] own_msg_code_i,
	output logic            tx_msg_valid_o,
	output logic [1:0]      tx_msg_addr_o,
	output logic [7:0]      tx_msg_code_o,
	// Payload streams
	input  wire logic       rx_data_i,
	input  wire logic       cust_data_i,
	output logic            xchg_data_o,
	output logic            cust_data_o,
	// Indicator bits per frame
	input  wire logic       frame_i,
	input  wire logic [7:0] rx_ind_i,
	input  wire logic [7:0] own_ind_i,
	input  wire logic [7:0] cust_ind_i,
	output logic [7:0]      tx_ind_o,
	// Customer-side transceiver control
	output logic            cust_reset_o,
	output logic            cust_deact_o,
	output logic            cust_start_o,
	// Status
	output logic            looped_o,
	output logic            remote_ready_o
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Message decode
	// ----------------------------------------------------------------
	function automatic logic is_msg(input logic [1:0] addr,
		input logic [7:0] code, input logic [7:0] want);
		return addr == loopback_pkg::REG_ADDR && code == want;
	endfunction : is_msg

	logic loop_req;
	logic ret_req;
	logic foreign;

	assign loop_req = msg_valid_i &&
		is_msg(msg_addr_i, msg_code_i, loopback_pkg::CODE_LOOP_REQ);
	assign ret_req  = msg_valid_i &&
		is_msg(msg_addr_i, msg_code_i, loopback_pkg::CODE_RETURN);
	assign foreign  = msg_valid_i && msg_addr_i != loopback_pkg::REG_ADDR;

	// ----------------------------------------------------------------
	// Loop state
	// ----------------------------------------------------------------
	loopback_pkg::loop_state_t state_q;
	logic [7:0]                rst_cnt_q;

	// Requests while the link is down are dropped, not queued
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= loopback_pkg::ST_NORMAL;
		end else begin
			case (state_q)
				loopback_pkg::ST_NORMAL: begin
					if (loop_req && xchg_active_i)
						state_q <= loopback_pkg::ST_LOOP_RST;
				end
				loopback_pkg::ST_LOOP_RST: begin
					if (!xchg_active_i)
						state_q <= loopback_pkg::ST_NORMAL;
					else if (rst_cnt_q == 8'h01)
						state_q <= loopback_pkg::ST_LOOPED;
				end
				loopback_pkg::ST_LOOPED: begin
					if (!xchg_active_i)
						state_q <= loopback_pkg::ST_NORMAL;
					else if (ret_req)
						state_q <= loopback_pkg::ST_RESTART;
				end
				loopback_pkg::ST_RESTART: begin
					state_q <= loopback_pkg::ST_NORMAL;
				end
				default: state_q <= loopback_pkg::ST_NORMAL;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q)
			rst_cnt_q <= 8'h00;
		else if (state_q == loopback_pkg::ST_NORMAL && loop_req &&
			xchg_active_i)
			rst_cnt_q <= 8'(RESET_CYCLES);
		else if (rst_cnt_q != 8'h00)
			rst_cnt_q <= rst_cnt_q - 8'h01;
	end

	// Loop closes immediately; reset phase already returns the signal
	logic looped;
	assign looped = state_q == loopback_pkg::ST_LOOP_RST ||
		state_q == loopback_pkg::ST_LOOPED;
	assign looped_o = looped;

	assign cust_reset_o = state_q == loopback_pkg::ST_LOOP_RST;
	assign cust_deact_o = state_q == loopback_pkg::ST_RESTART;
	// Restart only if exchange link still up
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q)
			cust_start_o <= 1'b0;
		else
			cust_start_o <= state_q == loopback_pkg::ST_RESTART &&
				xchg_active_i;
	end

	// ----------------------------------------------------------------
	// Data and indicator paths
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			xchg_data_o <= 1'b0;
			cust_data_o <= 1'b0;
		end else begin
			xchg_data_o <= looped ? rx_data_i : cust_data_i;
			cust_data_o <= rx_data_i;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q)
			tx_ind_o <= 8'h00;
		else if (looped)
			tx_ind_o <= (rx_ind_i & ~loopback_pkg::REG_IND_MASK) |
				(own_ind_i & loopback_pkg::REG_IND_MASK);
		else
			tx_ind_o <= (cust_ind_i & ~loopback_pkg::REG_IND_MASK) |
				(own_ind_i & loopback_pkg::REG_IND_MASK);
	end

	// ----------------------------------------------------------------
	// Operations channel toward the exchange side
	// ----------------------------------------------------------------
	// Hold answer wins over a regenerator message in the same cycle
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tx_msg_valid_o <= 1'b0;
			tx_msg_addr_o  <= 2'h0;
			tx_msg_code_o  <= 8'h00;
		end else if (looped && foreign) begin
			tx_msg_valid_o <= 1'b1;
			tx_msg_addr_o  <= loopback_pkg::REG_ADDR;
			tx_msg_code_o  <= loopback_pkg::CODE_HOLD;
		end else begin
			tx_msg_valid_o <= own_msg_valid_i;
			tx_msg_addr_o  <= loopback_pkg::REG_ADDR;
			tx_msg_code_o  <= own_msg_code_i;
		end
	end

	// ----------------------------------------------------------------
	// Remote-ready qualification
	// ----------------------------------------------------------------
	ready_filter #(
		.FRAMES(loopback_pkg::READY_FRAMES)
	) u_ready (
		.clock_i (clock_i),
		.rst_n_i (rst_n_q),
		.frame_i (frame_i),
		.bit_i   (cust_ind_i[loopback_pkg::READY_BIT]),
		.clear_i (looped),
		.ready_o (remote_ready_o)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_loop_closes: assert property (@(posedge clock_i)
		disable iff (!rst_n_q)
		state_q == loopback_pkg::ST_NORMAL && loop_req && xchg_active_i
		|=> looped_o && cust_reset_o)
		else $error("loop did not close on request");

	chk_hold_answer: assert property (@(posedge clock_i)
		disable iff (!rst_n_q)
		looped && foreign |=> tx_msg_valid_o &&
		tx_msg_code_o == loopback_pkg::CODE_HOLD &&
		tx_msg_addr_o == loopback_pkg::REG_ADDR)
		else $error("no hold answer to foreign address");

	chk_ind_loop: assert property (@(posedge clock_i)
		disable iff (!rst_n_q)
		looped |=> (tx_ind_o & ~loopback_pkg::REG_IND_MASK) ==
		($past(rx_ind_i) & ~loopback_pkg::REG_IND_MASK))
		else $error("indicators not looped");

	chk_reg_ind_own: assert property (@(posedge clock_i)
		disable iff (!rst_n_q)
		rst_n_q |=> (tx_ind_o & loopback_pkg::REG_IND_MASK) ==
		($past(own_ind_i) & loopback_pkg::REG_IND_MASK))
		else $error("regenerator indicators not kept");

	chk_transparent: assert property (@(posedge clock_i)
		disable iff (!rst_n_q)
		looped |=> cust_data_o == $past(rx_data_i) &&
		xchg_data_o == $past(rx_data_i))
		else $error("loop not transparent");

	chk_return_release: assert property (@(posedge clock_i)
		disable iff (!rst_n_q)
		state_q == loopback_pkg::ST_LOOPED && ret_req && xchg_active_i
		|=> cust_deact_o && !looped_o ##1 !looped_o)
		else $error("return message did not release loop");

	chk_restart: assert property (@(posedge clock_i)
		disable iff (!rst_n_q)
		cust_deact_o && xchg_active_i |=> cust_start_o)
		else $error("customer link not restarted");

	chk_loop_holds: assert property (@(posedge clock_i)
		disable iff (!rst_n_q)
		state_q == loopback_pkg::ST_LOOPED && xchg_active_i && !ret_req
		|=> state_q == loopback_pkg::ST_LOOPED)
		else $error("loop dropped without cause");

endmodule : regen_loopback_ctrl

// file: testbench/xchg_partner.sv
// Exchange-side line termination unit model: messages, payload, indicators
`timescale 1ns/100ps
module xchg_partner (
	// Clock and link state
	input  wire logic       clock_i,
	input  wire logic       active_i,
	output logic            xchg_active_o,
	// Operations channel toward the regenerator
	output logic            msg_valid_o,
	output logic [1:0]      msg_addr_o,
	output logic [7:0]      msg_code_o,
	// Payload and indicators toward the regenerator
	output logic            rx_data_o,
	output logic [7:0]      rx_ind_o
);
	logic [7:0] pat_q = 8'h3C;

	assign xchg_active_o = active_i;
	assign rx_data_o     = pat_q[0];
	assign rx_ind_o      = pat_q;

	// Pattern moves every cycle so a stale copy never matches
	always @(posedge clock_i) begin
		pat_q <= #1 {pat_q[6:0], pat_q[7] ^ pat_q[5] ^ ~pat_q[2]};
	end

	initial begin
		msg_valid_o = 1'b0;
		msg_addr_o  = 2'h0;
		msg_code_o  = 8'h00;
	end

	// Rude sends a loop request even while the link is down
	task automatic send(input logic [1:0] addr, input logic [7:0] code,
		input logic rude);
		if (rude || active_i || code !== loopback_pkg::CODE_LOOP_REQ) begin
			@(posedge clock_i);
			#1;
			msg_valid_o = 1'b1;
			msg_addr_o  = addr;
			msg_code_o  = code;
			@(posedge clock_i);
			#1;
			msg_valid_o = 1'b0;
			msg_addr_o  = ~addr;
			msg_code_o  = ~code;
		end
	endtask : send

	task automatic release_loop();
		send(loopback_pkg::REG_ADDR, loopback_pkg::CODE_RETURN, 1'b0);
	endtask : release_loop
endmodule : xchg_partner

// file: testbench/regenerator_loopback_control_tb.sv
// Self-checking bench for the regenerator loopback control
`timescale 1ns/100ps
`define CHECK(what, exp, got) begin \
	checked++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("Error %s expected %h seen %h", what, exp, got); \
	end \
end
module regenerator_loopback_control_tb;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic active = 1'b0;
	logic xchg_active, msg_valid, rx_data, cust_data = 1'b0, frame = 1'b0;
	logic [1:0] msg_addr;
	logic [7:0] msg_code, rx_ind, own_ind = 8'h5A, cust_ind = 8'h00;
	logic tx_valid, xchg_data, cust_data_o, cust_reset, cust_deact;
	logic cust_start, looped, ready;
	logic [1:0] tx_addr;
	logic [7:0] tx_code, tx_ind;
	logic own_valid = 1'b0;
	logic [7:0] own_code = 8'h00;
	int miscompares = 0;
	int checked = 0;

	always #5 clock_i = ~clock_i;

	xchg_partner lt (.clock_i(clock_i), .active_i(active),
		.xchg_active_o(xchg_active), .msg_valid_o(msg_valid),
		.msg_addr_o(msg_addr), .msg_code_o(msg_code),
		.rx_data_o(rx_data), .rx_ind_o(rx_ind));

	regen_loopback_ctrl #(.RESET_CYCLES(2)) dut (.clock_i(clock_i),
		.rstn_i(rstn_i), .xchg_active_i(xchg_active),
		.msg_valid_i(msg_valid), .msg_addr_i(msg_addr),
		.msg_code_i(msg_code), .own_msg_valid_i(own_valid),
		.own_msg_code_i(own_code), .tx_msg_valid_o(tx_valid),
		.tx_msg_addr_o(tx_addr), .tx_msg_code_o(tx_code),
		.rx_data_i(rx_data), .cust_data_i(cust_data),
		.xchg_data_o(xchg_data), .cust_data_o(cust_data_o),
		.frame_i(frame), .rx_ind_i(rx_ind), .own_ind_i(own_ind),
		.cust_ind_i(cust_ind), .tx_ind_o(tx_ind),
		.cust_reset_o(cust_reset), .cust_deact_o(cust_deact),
		.cust_start_o(cust_start), .looped_o(looped),
		.remote_ready_o(ready));

	task automatic tick();
		@(posedge clock_i);
		#1;
	endtask : tick

	task automatic t_ready();
		cust_ind = 8'h08;
		for (int i = 0; i < 6; i++) begin
			frame = 1'b1;
			tick();
			frame = 1'b0;
			tick();
			if (i == 4) `CHECK("ready early", 1'b0, ready)
		end
		tick();
		`CHECK("ready", 1'b1, ready)
	endtask : t_ready

	task automatic t_refused();
		active = 1'b0;
		lt.send(loopback_pkg::REG_ADDR, loopback_pkg::CODE_LOOP_REQ, 1'b1);
		tick();
		`CHECK("loop inactive", 1'b0, looped)
		active = 1'b1;
		tick();
	endtask : t_refused

	task automatic t_enter();
		lt.send(loopback_pkg::REG_ADDR, loopback_pkg::CODE_LOOP_REQ, 1'b0);
		`CHECK("looped", 1'b1, looped)
		`CHECK("reset", 1'b1, cust_reset)
		tick();
		`CHECK("reset hold", 1'b1, cust_reset)
		tick();
		`CHECK("reset end", 1'b0, cust_reset)
		`CHECK("loop held", 1'b1, looped)
	endtask : t_enter

	task automatic t_stream(input logic lp);
		logic rv, cv;
		logic [7:0] ri, ci;
		for (int i = 0; i < 4; i++) begin
			cust_data = i[0];
			cust_ind = 8'hC3 ^ i[7:0];
			own_ind = 8'hA5 ^ i[7:0];
			#1;
			rv = rx_data;
			cv = cust_data;
			ri = rx_ind;
			ci = cust_ind;
			tick();
			`CHECK("cust data", rv, cust_data_o)
			`CHECK("xchg data", lp ? rv : cv, xchg_data)
			`CHECK("ind", {lp ? ri[7:3] : ci[7:3], own_ind[2:0]}, tx_ind)
		end
	endtask : t_stream

	task automatic t_hold();
		lt.send(2'h1, loopback_pkg::CODE_LOOP_REQ, 1'b0);
		`CHECK("hold valid", 1'b1, tx_valid)
		`CHECK("hold addr", loopback_pkg::REG_ADDR, tx_addr)
		`CHECK("hold code", loopback_pkg::CODE_HOLD, tx_code)
		lt.send(loopback_pkg::REG_ADDR, 8'h10, 1'b0);
		`CHECK("own no hold", 1'b0, tx_valid)
		`CHECK("own looped", 1'b1, looped)
		own_valid = 1'b1;
		own_code = 8'h21;
		tick();
		own_valid = 1'b0;
		`CHECK("own msg valid", 1'b1, tx_valid)
		`CHECK("own msg code", 8'h21, tx_code)
		`CHECK("own msg addr", loopback_pkg::REG_ADDR, tx_addr)
	endtask : t_hold

	task automatic t_release();
		lt.release_loop();
		`CHECK("unlooped", 1'b0, looped)
		`CHECK("deact", 1'b1, cust_deact)
		tick();
		`CHECK("start", 1'b1, cust_start)
		`CHECK("deact end", 1'b0, cust_deact)
		tick();
		`CHECK("start end", 1'b0, cust_start)
	endtask : t_release

	task automatic t_drop();
		t_enter();
		active = 1'b0;
		tick();
		`CHECK("drop unloop", 1'b0, looped)
		tick();
		`CHECK("no start", 1'b0, cust_start)
		active = 1'b1;
		tick();
	endtask : t_drop

	task automatic finish_test();
		$display("Checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test

	// ------------------------------------------------------------
	// Watchdog: whole run needs well under 200 cycles
	// ------------------------------------------------------------
	initial begin
		#20000;
		miscompares++;
		finish_test();
	end

	initial begin
		repeat (2) @(posedge clock_i);
		#1;
		rstn_i = 1'b1;
		repeat (3) tick();
		`CHECK("idle loop", 1'b0, looped)
		t_ready();
		t_refused();
		t_stream(1'b0);
		t_enter();
		t_stream(1'b1);
		t_hold();
		t_release();
		t_stream(1'b0);
		t_drop();
		finish_test();
	end
endmodule : regenerator_loopback_control_tb
